// >>> design/ddp_cfg.svh
`ifndef DDP_CFG_SVH
`define DDP_CFG_SVH

// ********
// Clock and timing
// ********
`define DDP_CLK_PERIOD_NS 50
`define DDP_PROG_TIME_NS 5600000
`define DDP_PROG_CYCLES (`DDP_PROG_TIME_NS / `DDP_CLK_PERIOD_NS)
`define DDP_PROG_DELAY_FCLK 8'h40
`define DDP_END_TIMEOUT_FCLK 8'hC8

// ********
// Reference pulse limits (field clocks)
// ********
`define DDP_REF_MIN_NORM 8'h0C
`define DDP_REF_MAX_NORM 8'h48
`define DDP_REF_MIN_FAST 8'h08
`define DDP_REF_MAX_FAST 8'h44

// ********
// Pair windows relative to reference, signed 10 bit
// ********
`define DDP_N00_LO (-10'sd7)
`define DDP_N00_HI 10'sd8
`define DDP_N01_HI 10'sd24
`define DDP_N10_HI 10'sd40
`define DDP_N11_HI 10'sd56
`define DDP_F00_LO (-10'sd3)
`define DDP_F00_HI 10'sd4
`define DDP_F01_HI 10'sd12
`define DDP_F10_HI 10'sd20
`define DDP_F11_HI 10'sd28

// ********
// Command bit counts and password block
// ********
`define DDP_LEN_SHORT 7'h02
`define DDP_LEN_DIRECT 7'h06
`define DDP_LEN_WRITE 7'h26
`define DDP_LEN_PW_WRITE 7'h48
`define DDP_LEN_PW_DIRECT 7'h28
`define DDP_LEN_PW_WAKE 7'h24
`define DDP_PASSWORD_BLOCK 4'h7

// ********
// Register offsets and fields
// ********
`define DDP_REG_CTRL 8'h00
`define DDP_REG_STATUS 8'h04
`define DDP_REG_MEMSEL 8'h08
`define DDP_REG_MEMDATA 8'h0C
`define DDP_REG_MEMLOCK 8'h10
`define DDP_CTRL_FAST 0
`define DDP_CTRL_PWMODE 1
`define DDP_CTRL_WAKE 2
`define DDP_CTRL_VFAIL 3
`define DDP_STAT_ERR 9
`define DDP_CTRL_RESET 4'h0

`endif

// >>> design/ddp_pkg.sv
package ddp_pkg;
    typedef enum logic [1:0] {
        DDP_MODE_REGULAR = 2'b00,
        DDP_MODE_BLOCK = 2'b01,
        DDP_MODE_DEFEAT = 2'b10,
        DDP_MODE_PROG = 2'b11
    } ddp_mode_t;

    typedef enum logic [1:0] {
        DDP_RX_IDLE = 2'b00,
        DDP_RX_REF = 2'b01,
        DDP_RX_DATA = 2'b10,
        DDP_RX_DONE = 2'b11
    } ddp_rx_t;

    typedef enum logic [2:0] {
        DDP_PG_IDLE = 3'b000,
        DDP_PG_DELAY = 3'b001,
        DDP_PG_ERASE = 3'b010,
        DDP_PG_EVER = 3'b011,
        DDP_PG_PROG = 3'b100,
        DDP_PG_WVER = 3'b101
    } ddp_pg_t;
endpackage

// >>> design/ddp_core.sv
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "ddp_cfg.svh"
// Summary of operation
// [RULE1] Command sent as bit pairs, six lengths
// [RULE2] Reference pulse 00 precedes, bounded length
// [RULE3] Measured reference classifies all following pairs
// [RULE4] Reader opens command with start gap
// [RULE5] Reader separates symbols with short gaps
// [RULE6] Pair windows offset from reference length
// [RULE7] Programming starts after fixed clock delay
// [RULE8] Programming cycle lasts about 5.6 ms
// [RULE9] Success leads to single-block read
// [RULE10] Data and lock bit written together
// [RULE11] Erase, verify zero, program, verify ones
// [RULE12] Page 1 program holds page 1 reading
// [RULE13] Invalid interval length flags command error
// [RULE14] Password mismatch flags command error
// [RULE15] Unprotected lengths 38, 6, 2 bits
// [RULE16] Protected lengths 72, 40, 36 bits
// [RULE17] Errors enter regular read, block 1
// [RULE18] Bad wake-up command stops modulation
// [RULE19] Locked block skips programming, reads block
// [RULE20] Verify failure stops modulation until command
// [RULE21] Field-clock counter restarts at gap end
module ddp_core
    import ddp_pkg::*;
#(
    parameter int P_PROG_CYCLES = `DDP_PROG_CYCLES
)(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_field_clk,
    input wire logic i_gap,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    output logic [1:0] o_read_mode,
    output logic o_mod_enable,
    output logic o_read_page,
    output logic [2:0] o_read_block,
    output logic o_prog_busy
);
    localparam int STEP_CYC = P_PROG_CYCLES / 4;

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Pair classification against the measured reference; bit 2 = invalid
    function automatic logic [2:0] classify(input logic [7:0] len, input logic [7:0] ref_len,
                                            input logic fast);
        logic signed [9:0] d;
        d = $signed({2'b00, len}) - $signed({2'b00, ref_len});
        classify = 3'b100;
        if (!fast) begin
            if (d >= `DDP_N00_LO && d <= `DDP_N00_HI) classify = 3'b000; // [RULE6]
            else if (d > `DDP_N00_HI && d <= `DDP_N01_HI) classify = 3'b001;
            else if (d > `DDP_N01_HI && d <= `DDP_N10_HI) classify = 3'b010;
            else if (d > `DDP_N10_HI && d <= `DDP_N11_HI) classify = 3'b011;
        end else begin
            if (d >= `DDP_F00_LO && d <= `DDP_F00_HI) classify = 3'b000; // [RULE6]
            else if (d > `DDP_F00_HI && d <= `DDP_F01_HI) classify = 3'b001;
            else if (d > `DDP_F01_HI && d <= `DDP_F10_HI) classify = 3'b010;
            else if (d > `DDP_F10_HI && d <= `DDP_F11_HI) classify = 3'b011;
        end
    endfunction

    // Bounds check shared by reference pulse tests
    function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    logic fclk_m_q, fclk_s_q, fclk_p_q;
    logic gap_m_q, gap_s_q, gap_p_q;
    logic fclk_rise, gap_end, gap_start;

    // Async pins; the first stage feeds only the second
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fclk_m_q <= 1'b0;
            fclk_s_q <= 1'b0;
            fclk_p_q <= 1'b0;
            gap_m_q <= 1'b0;
            gap_s_q <= 1'b0;
            gap_p_q <= 1'b0;
        end else begin
            fclk_m_q <= i_field_clk;
            fclk_s_q <= fclk_m_q;
            fclk_p_q <= fclk_s_q;
            gap_m_q <= i_gap;
            gap_s_q <= gap_m_q;
            gap_p_q <= gap_s_q;
        end
    end

    assign fclk_rise = fclk_s_q & ~fclk_p_q;
    assign gap_end = ~gap_s_q & gap_p_q;
    assign gap_start = gap_s_q & ~gap_p_q;

    // ****************************************************************
    // Register file and block memory
    // ****************************************************************
    logic [3:0] ctrl_q;
    logic [3:0] memsel_q;
    logic err_flag_q;
    logic [31:0] mem_data [16];
    logic mem_lock [16];
    logic wr_ctrl, wr_stat, wr_sel, wr_data, wr_lock;
    logic cmd_err_evt;
    logic [31:0] rdata_d;
    ddp_mode_t mode_q;
    ddp_pg_t pg_q;
    logic page_q;
    logic [2:0] block_q;

    assign wr_ctrl = i_reg_wr && (i_reg_addr == `DDP_REG_CTRL);
    assign wr_stat = i_reg_wr && (i_reg_addr == `DDP_REG_STATUS);
    assign wr_sel = i_reg_wr && (i_reg_addr == `DDP_REG_MEMSEL);
    assign wr_data = i_reg_wr && (i_reg_addr == `DDP_REG_MEMDATA);
    assign wr_lock = i_reg_wr && (i_reg_addr == `DDP_REG_MEMLOCK);

    // Configuration steering the decoder and programming sequence
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_q <= `DDP_CTRL_RESET;
            memsel_q <= 4'h0;
        end else begin
            if (wr_ctrl) ctrl_q <= i_reg_wdata[3:0];
            if (wr_sel) memsel_q <= i_reg_wdata[3:0];
        end
    end

    // Sticky error; a new error in the clearing cycle wins
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) err_flag_q <= 1'b0;
        else if (cmd_err_evt) err_flag_q <= 1'b1;
        else if (wr_stat && i_reg_wdata[`DDP_STAT_ERR]) err_flag_q <= 1'b0;
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (i_reg_addr)
            `DDP_REG_CTRL: rdata_d = {28'h0, ctrl_q};
            `DDP_REG_STATUS: rdata_d = {23'h0, err_flag_q, pg_q != DDP_PG_IDLE, o_mod_enable,
                                        page_q, block_q, mode_q};
            `DDP_REG_MEMSEL: rdata_d = {28'h0, memsel_q};
            `DDP_REG_MEMDATA: rdata_d = mem_data[memsel_q];
            `DDP_REG_MEMLOCK: rdata_d = {31'h0, mem_lock[memsel_q]};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) o_reg_rdata <= 32'h0000_0000;
        else if (i_reg_rd) o_reg_rdata <= rdata_d;
        else o_reg_rdata <= 32'h0000_0000;
    end

    // ****************************************************************
    // Gap interval measurement and pair decoding
    // ****************************************************************
    ddp_rx_t rx_q;
    logic [7:0] cnt_q, ref_q;
    logic [71:0] cmd_q;
    logic [6:0] nbits_q;
    logic bad_q;
    logic [2:0] cls;
    logic fast;

    assign fast = ctrl_q[`DDP_CTRL_FAST];
    assign cls = classify(cnt_q, ref_q, fast);

    // Counts field clocks; restarts at every gap end, saturates at the top
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) cnt_q <= 8'h00;
        else if (gap_end) cnt_q <= 8'h00; // [RULE21]
        else if (fclk_rise && cnt_q != 8'hFF) cnt_q <= cnt_q + 8'h01;
    end

    // Frame sequencing: start gap, reference, data pairs, silence ends it
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_q <= DDP_RX_IDLE;
            ref_q <= 8'h00;
            cmd_q <= 72'h0;
            nbits_q <= 7'h00;
            bad_q <= 1'b0;
        end else begin
            case (rx_q)
                DDP_RX_IDLE: begin
                    // Start gap length is the reader's concern
                    if (gap_end && pg_q == DDP_PG_IDLE) begin // [RULE4]
                        rx_q <= DDP_RX_REF;
                        nbits_q <= 7'h00;
                        bad_q <= 1'b0;
                        cmd_q <= 72'h0;
                    end
                end
                DDP_RX_REF: begin
                    if (gap_end) begin
                        ref_q <= cnt_q; // [RULE3]
                        rx_q <= DDP_RX_DATA;
                        if (fast ? !in_range(cnt_q, `DDP_REF_MIN_FAST, `DDP_REF_MAX_FAST)
                                 : !in_range(cnt_q, `DDP_REF_MIN_NORM, `DDP_REF_MAX_NORM))
                            bad_q <= 1'b1; // [RULE2]
                    end else if (cnt_q >= `DDP_END_TIMEOUT_FCLK) begin
                        rx_q <= DDP_RX_IDLE;
                    end
                end
                DDP_RX_DATA: begin
                    // Each gap-to-gap interval carries one pair
                    if (gap_end) begin
                        if (cls[2]) bad_q <= 1'b1; // [RULE13]
                        cmd_q <= {cmd_q[69:0], cls[1:0]}; // [RULE1]
                        if (nbits_q < `DDP_LEN_PW_WRITE) nbits_q <= nbits_q + 7'h02;
                        else bad_q <= 1'b1;
                    end else if (cnt_q >= `DDP_END_TIMEOUT_FCLK) begin
                        rx_q <= DDP_RX_DONE;
                    end
                end
                DDP_RX_DONE: rx_q <= DDP_RX_IDLE;
                default: rx_q <= DDP_RX_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Command validation
    // ****************************************************************
    logic pw_mode, wake_en, frame_done;
    logic [1:0] op;
    logic [31:0] rx_pw, rx_data;
    logic [2:0] rx_addr;
    logic rx_lock, pw_ok;
    logic is_reset, is_read, is_write, is_direct, is_wake, len_ok;

    assign pw_mode = ctrl_q[`DDP_CTRL_PWMODE];
    assign wake_en = ctrl_q[`DDP_CTRL_WAKE];
    assign frame_done = (rx_q == DDP_RX_DONE);

    // Field extraction by received length; protected frames end in two pad bits
    always_comb begin
        op = 2'b00;
        rx_pw = 32'h0000_0000;
        rx_data = 32'h0000_0000;
        rx_addr = 3'h0;
        rx_lock = 1'b0;
        case (nbits_q)
            `DDP_LEN_SHORT: op = cmd_q[1:0];
            `DDP_LEN_DIRECT: begin
                op = cmd_q[5:4];
                rx_addr = cmd_q[2:0];
            end
            `DDP_LEN_WRITE: begin
                op = cmd_q[37:36];
                rx_lock = cmd_q[35];
                rx_data = cmd_q[34:3];
                rx_addr = cmd_q[2:0];
            end
            `DDP_LEN_PW_WRITE: begin
                op = cmd_q[71:70];
                rx_pw = cmd_q[69:38];
                rx_lock = cmd_q[37];
                rx_data = cmd_q[36:5];
                rx_addr = cmd_q[4:2];
            end
            `DDP_LEN_PW_DIRECT: begin
                op = cmd_q[39:38];
                rx_pw = cmd_q[37:6];
                rx_addr = cmd_q[4:2];
            end
            `DDP_LEN_PW_WAKE: begin
                op = cmd_q[35:34];
                rx_pw = cmd_q[33:2];
            end
            default: if (nbits_q != 7'h00) op = cmd_q[nbits_q - 7'h01 -: 2]; // [RULE17]
        endcase
    end

    assign pw_ok = (rx_pw == mem_data[`DDP_PASSWORD_BLOCK]); // [RULE14]
    assign is_reset = (nbits_q == `DDP_LEN_SHORT) && (op == 2'b00);
    assign is_read = (nbits_q == `DDP_LEN_SHORT) && op[1];
    // Length acceptance depends on protection mode
    assign is_write = op[1] && (pw_mode ? nbits_q == `DDP_LEN_PW_WRITE // [RULE16]
                                        : nbits_q == `DDP_LEN_WRITE); // [RULE15]
    assign is_direct = op[1] && (pw_mode ? nbits_q == `DDP_LEN_PW_DIRECT
                                         : nbits_q == `DDP_LEN_DIRECT);
    assign is_wake = pw_mode && wake_en && (nbits_q == `DDP_LEN_PW_WAKE);
    assign len_ok = is_reset || is_read || is_write || is_direct;
    assign cmd_err_evt = frame_done && (bad_q || !(len_ok || is_wake) ||
                         (pw_mode && (is_write || is_direct || is_wake) && !pw_ok));

    // ****************************************************************
    // Programming sequencer and read mode
    // ****************************************************************
    logic [31:0] step_q;
    logic [7:0] dly_q;
    logic [3:0] pidx_q;
    logic [31:0] pdata_q;
    logic plock_q;
    logic vfail_q;
    logic hold_p1_q;
    logic step_done;

    assign step_done = (step_q == 32'(STEP_CYC - 1));

    // Memory: register preload when idle, otherwise the programming steps
    always_ff @(posedge i_core_clk) begin
        if (pg_q == DDP_PG_ERASE && step_done) begin
            mem_data[pidx_q] <= 32'h0000_0000;
            mem_lock[pidx_q] <= 1'b0;
        end else if (pg_q == DDP_PG_PROG && step_done) begin
            mem_data[pidx_q] <= pdata_q; // [RULE10]
            mem_lock[pidx_q] <= plock_q;
        end else if (pg_q == DDP_PG_IDLE && wr_data) begin
            mem_data[memsel_q] <= i_reg_wdata;
        end else if (pg_q == DDP_PG_IDLE && wr_lock) begin
            mem_lock[memsel_q] <= i_reg_wdata[0];
        end
    end

    // Step timer; four equal steps make up the whole cycle
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) step_q <= 32'h0000_0000;
        else if (pg_q == DDP_PG_IDLE || pg_q == DDP_PG_DELAY || step_done)
            step_q <= 32'h0000_0000;
        else step_q <= step_q + 32'h0000_0001; // [RULE8]
    end

    // Main sequencer: acts on a completed frame, then runs the programming steps
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pg_q <= DDP_PG_IDLE;
            mode_q <= DDP_MODE_REGULAR;
            page_q <= 1'b0;
            block_q <= 3'h1;
            dly_q <= 8'h00;
            pidx_q <= 4'h0;
            pdata_q <= 32'h0000_0000;
            plock_q <= 1'b0;
            vfail_q <= 1'b0;
            hold_p1_q <= 1'b0;
        end else begin
            case (pg_q)
                DDP_PG_IDLE: begin
                    if (frame_done) begin
                        if (cmd_err_evt && is_wake) begin
                            mode_q <= DDP_MODE_DEFEAT; // [RULE18]
                        end else if (cmd_err_evt) begin
                            mode_q <= DDP_MODE_REGULAR; // [RULE17]
                            page_q <= op[0];
                            block_q <= 3'h1;
                        end else if (is_reset) begin
                            mode_q <= DDP_MODE_REGULAR;
                            page_q <= 1'b0;
                            block_q <= 3'h1;
                            hold_p1_q <= 1'b0; // [RULE12]
                        end else if (is_read) begin
                            // After a page 1 write the read stays on page 1
                            mode_q <= DDP_MODE_REGULAR;
                            page_q <= op[0] | hold_p1_q; // [RULE12]
                            block_q <= 3'h1;
                        end else if (is_wake) begin
                            mode_q <= DDP_MODE_REGULAR;
                            block_q <= 3'h1;
                        end else if (is_direct) begin
                            mode_q <= DDP_MODE_BLOCK;
                            page_q <= op[0];
                            block_q <= rx_addr;
                        end else if (mem_lock[{op[0], rx_addr}]) begin
                            mode_q <= DDP_MODE_BLOCK; // [RULE19]
                            page_q <= op[0];
                            block_q <= rx_addr;
                        end else begin
                            mode_q <= DDP_MODE_PROG;
                            page_q <= op[0];
                            block_q <= rx_addr;
                            pidx_q <= {op[0], rx_addr};
                            pdata_q <= rx_data;
                            plock_q <= rx_lock;
                            vfail_q <= ctrl_q[`DDP_CTRL_VFAIL];
                            dly_q <= 8'h00;
                            pg_q <= DDP_PG_DELAY; // [RULE7]
                        end
                    end
                end
                DDP_PG_DELAY: begin
                    // Counted in field clocks after the command's end
                    if (fclk_rise) dly_q <= dly_q + 8'h01;
                    if (dly_q == `DDP_PROG_DELAY_FCLK) pg_q <= DDP_PG_ERASE; // [RULE7]
                end
                DDP_PG_ERASE: if (step_done) pg_q <= DDP_PG_EVER; // [RULE11]
                DDP_PG_EVER: begin
                    if (step_done) begin
                        if (vfail_q || mem_data[pidx_q] != 32'h0000_0000) begin
                            pg_q <= DDP_PG_IDLE;
                            mode_q <= DDP_MODE_DEFEAT; // [RULE20]
                        end else begin
                            pg_q <= DDP_PG_PROG; // [RULE11]
                        end
                    end
                end
                DDP_PG_PROG: if (step_done) pg_q <= DDP_PG_WVER; // [RULE11]
                DDP_PG_WVER: begin
                    if (step_done) begin
                        pg_q <= DDP_PG_IDLE;
                        // Every bit meant to be one must read back as one
                        if ((mem_data[pidx_q] & pdata_q) != pdata_q ||
                            mem_lock[pidx_q] != plock_q) begin
                            mode_q <= DDP_MODE_DEFEAT; // [RULE20]
                        end else begin
                            mode_q <= DDP_MODE_BLOCK; // [RULE9]
                            if (pidx_q[3]) hold_p1_q <= 1'b1;
                        end
                    end
                end
                default: pg_q <= DDP_PG_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Registered so the load switch never glitches on decode paths
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) o_mod_enable <= 1'b0;
        else o_mod_enable <= (mode_q == DDP_MODE_REGULAR) || (mode_q == DDP_MODE_BLOCK);
    end

    assign o_read_mode = mode_q;
    assign o_read_page = page_q;
    assign o_read_block = block_q;
    assign o_prog_busy = (pg_q != DDP_PG_IDLE);

endmodule

// >>> verif/ddp_checker.sv
`timescale 1ns/1ps
// ********
// Port checker
// ********
module ddp_checker
    import ddp_pkg::*;
#(
    parameter int P_PROG_CYCLES = 400
)(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_field_clk,
    input wire logic i_gap,
    input wire logic [1:0] o_read_mode,
    input wire logic o_mod_enable,
    input wire logic o_read_page,
    input wire logic [2:0] o_read_block,
    input wire logic o_prog_busy
);
    logic fclk_q;
    logic [7:0] quiet_q;
    logic [15:0] busy_q;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // Field clocks since the last gap, saturating
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fclk_q <= 1'b0;
            quiet_q <= 8'h00;
        end else begin
            fclk_q <= i_field_clk;
            if (i_gap) quiet_q <= 8'h00;
            else if (i_field_clk && !fclk_q && quiet_q != 8'hFF) quiet_q <= quiet_q + 8'h01;
        end
    end
    // Core cycles busy in this programming cycle
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) busy_q <= 16'h0000;
        else if (!o_prog_busy) busy_q <= 16'h0000;
        else if (busy_q != 16'hFFFF) busy_q <= busy_q + 16'h0001;
    end
    property p_mod; $past(i_rst_b)
        |-> o_mod_enable == ($past(o_read_mode) inside {2'b00, 2'b01}); endproperty
    a_mod: assert property (p_mod) else $error("modulation does not follow mode");
    property p_defeat; o_read_mode == DDP_MODE_DEFEAT [*2] |-> !o_mod_enable; endproperty
    a_defeat: assert property (p_defeat) else $error("modulating while defeated");
    property p_time; $fell(o_prog_busy) |-> int'(busy_q) >= P_PROG_CYCLES; endproperty
    a_time: assert property (p_time) else $error("programming too short");
    property p_done; $fell(o_prog_busy) |-> ##[0:1] o_read_mode inside {2'b01, 2'b10}; endproperty
    a_done: assert property (p_done) else $error("no block read after program");
    property p_reg; o_read_mode == DDP_MODE_REGULAR |-> o_read_block == 3'h1; endproperty
    a_reg: assert property (p_reg) else $error("regular read not from block 1");
    property p_acc; $rose(o_prog_busy) |-> quiet_q >= 8'hBE; endproperty
    a_acc: assert property (p_acc) else $error("write taken before frame end");
    property p_act; $changed(o_read_mode) && !o_prog_busy && !$past(o_prog_busy)
        |-> quiet_q >= 8'hBE; endproperty
    a_act: assert property (p_act) else $error("mode changed inside a frame");
    property p_hold; $rose(o_prog_busy) |=> o_prog_busy [*8]; endproperty
    a_hold: assert property (p_hold) else $error("programming cut short");
    c_prog: cover property ($fell(o_prog_busy));
    c_defeat: cover property (o_read_mode == DDP_MODE_DEFEAT);
    c_page: cover property (o_read_page);
endmodule
bind ddp_core ddp_checker #(.P_PROG_CYCLES(P_PROG_CYCLES)) u_chk(.i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b), .i_field_clk(i_field_clk), .i_gap(i_gap), .o_read_mode(o_read_mode),
    .o_mod_enable(o_mod_enable), .o_read_page(o_read_page), .o_read_block(o_read_block),
    .o_prog_busy(o_prog_busy));

// >>> verif/ddp_reader.sv
`timescale 1ns/1ps
// ********
// Reader model
// ********
module ddp_reader(
    output logic o_field_clk = 1'b0,
    output logic o_gap = 1'b0
);
    // Field runs free, halting only in a gap
    always #200 if (!o_gap) o_field_clk = ~o_field_clk;
    task hole(input int n);
        o_gap = 1'b1;
        #(n * 400);
        o_gap = 1'b0;
    endtask
    // Fresh reference per frame tests tracking
    task send(input logic [71:0] b, input int np, input int extra);
        int r;
        r = 20 + $urandom % 30;
        #13;
        hole(15);
        #(r * 400);
        for (int i = np - 1; i >= 0; i--) begin
            hole(10);
            #((r + 16 * b[2*i+:2] + extra) * 400);
        end
        hole(10);
        #(240 * 400);
    endtask
endmodule

// >>> verif/ddp_core_tb.sv
`timescale 1ns/1ps
// ********
// Bench
// ********
module ddp_core_tb;
    import ddp_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_reg_wr = 1'b0, i_reg_rd = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [31:0] i_reg_wdata = 32'h0;
    logic [31:0] o_reg_rdata, d;
    logic [1:0] o_read_mode;
    logic [2:0] o_read_block, a;
    logic o_mod_enable, o_read_page, o_prog_busy, fclk, gap;
    int fail_count = 0, cmp_count = 0;
    always #25 i_core_clk = ~i_core_clk;
    ddp_reader rdr(.o_field_clk(fclk), .o_gap(gap));
    // Short programming keeps the run brief
    ddp_core #(.P_PROG_CYCLES(400)) dut(.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_field_clk(fclk), .i_gap(gap), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
        .o_read_mode(o_read_mode), .o_mod_enable(o_mod_enable), .o_read_page(o_read_page),
        .o_read_block(o_read_block), .o_prog_busy(o_prog_busy));
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [7:0] ad, input logic [31:0] v);
        @(posedge i_core_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= ad;
        i_reg_wdata <= v;
        @(posedge i_core_clk);
        i_reg_wr <= 1'b0;
    endtask
    task rdchk(input logic [7:0] ad, input logic [31:0] e);
        @(posedge i_core_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= ad;
        @(posedge i_core_clk);
        i_reg_rd <= 1'b0;
        #1 chk("register", e, o_reg_rdata);
    endtask
    task look(input ddp_mode_t m, input logic [2:0] b, input logic p);
        chk("view", {26'h0, p, b, m}, {26'h0, o_read_page, o_read_block, o_read_mode});
    endtask
    // Sticky error must be set; then clear it
    task errchk;
        rdchk(8'h04, 32'h144);
        wr(8'h04, 32'h200);
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hDAA9A343));
        repeat (2) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        // Page 1 write and locked retry, then forced verify failure
        for (int k = 0; k < 2; k++) begin
            a = 3'(1 + k + 2 * ($urandom % 3));
            d = $urandom;
            wr(8'h08, {28'h0, k == 0, a});
            wr(8'h10, 32'h0);
            wr(8'h00, 32'(k * 8));
            rdr.send({1'b1, k == 0, 1'b1, d, a}, 19, 0);
            chk("busy", 32'h1, {31'h0, o_prog_busy});
            for (int i = 0; i < 4000 && o_prog_busy !== 1'b0; i++) @(posedge i_core_clk);
            #1 look(k ? DDP_MODE_DEFEAT : DDP_MODE_BLOCK, a, k == 0);
            if (k == 0) begin
                rdchk(8'h0C, d);
                rdchk(8'h10, 32'h1);
                rdr.send({2'b11, 1'b0, ~d, a}, 19, 0);
                chk("busy", 32'h0, {31'h0, o_prog_busy});
                look(DDP_MODE_BLOCK, a, 1'b1);
                rdchk(8'h0C, d);
            end
        end
        // Bad symbol, bad count, then a fast read held on page 1
        wr(8'h00, 32'h0);
        rdr.send(72'h2, 1, 70);
        errchk();
        rdr.send(72'hA5, 4, 0);
        errchk();
        wr(8'h00, 32'h1);
        rdr.send(72'h2, 1, -16);
        rdchk(8'h04, 32'h64);
        // Wrong wake-up password silences modulation
        d = $urandom;
        wr(8'h08, 32'h7);
        wr(8'h0C, d);
        wr(8'h00, 32'h6);
        rdr.send({2'b10, ~d, 2'b00}, 18, 0);
        chk("mode", 32'h2, {30'h0, o_read_mode});
        chk("modulation", 32'h0, {31'h0, o_mod_enable});
        summarize();
    end
    // The run needs about 65k cycles
    initial begin
        #(95000 * 50);
        fail_count++;
        summarize();
    end
endmodule
